// file: srcmb_top.v
// System reset combiner with an AXI4-Lite software reset trigger register
//
// Overview
//   Six reset causes are turned active high and merged into one level.
//   The merged level drives the chip-wide master reset through a stretcher,
//   which keeps the reset asserted for a fixed number of cycles after the
//   last cause has gone away, so short glitches still give a full reset.
//
// Software path
//   A write of one to bit 0 of the trigger word, while the unlock level is
//   high, sets an internal trigger bit for exactly one cycle. The bit clears
//   itself on the next edge, so it never stays latched. One edge later the
//   software reset event pulses for one cycle and joins the other causes.
//   A write of one while locked completes normally but only sets a sticky
//   refused mark in the status word; software clears that mark by writing
//   one to its bit with byte lane one enabled.
//
// Bus behaviour
//   Address and data of a write may arrive in either order or together.
//   The response follows one edge after the pair is complete. Reads answer
//   one edge after the address is taken. Unmapped addresses give an error
//   response and have no effect.
//
// Limitations
//   The unlock level is taken as a live input; the sequence that makes it
//   belongs elsewhere. Power-on is treated as a synchronous level here.
//   The block's own reset is separate from the master reset it produces;
//   looping one back into the other is left to the integrator.
//
// Latency summary
//   Cause active at an edge: master reset high after that edge.
//   Trigger write completing at an edge: event one edge later, master
//   reset two edges later.
//
`include "srcmb_map.vh"

module srcmb_top #(
  parameter HOLD  = `SRCMB_HOLD_CYCLES,
  parameter CNT_W = 8
) (
  input  wire                     aclk,                         // System clock, 100 MHz
  input  wire                     aresetn,                      // Synchronous reset, active low
  // Write address channel
  input  wire [`SRCMB_ADDR_W-1:0] s_axi_awaddr,                 // Write byte address
  input  wire [2:0]               s_axi_awprot,                 // Protection, unused
  input  wire                     s_axi_awvalid,                // Write address valid
  output wire                     s_axi_awready,                // Write address ready
  // Write data channel
  input  wire [`SRCMB_DATA_W-1:0] s_axi_wdata,                  // Write data
  input  wire [3:0]               s_axi_wstrb,                  // Byte enables
  input  wire                     s_axi_wvalid,                 // Write data valid
  output wire                     s_axi_wready,                 // Write data ready
  // Write response channel
  output reg  [1:0]               s_axi_bresp,                  // Write response
  output reg                      s_axi_bvalid,                 // Write response valid
  input  wire                     s_axi_bready,                 // Write response ready
  // Read address channel
  input  wire [`SRCMB_ADDR_W-1:0] s_axi_araddr,                 // Read byte address
  input  wire [2:0]               s_axi_arprot,                 // Protection, unused
  input  wire                     s_axi_arvalid,                // Read address valid
  output wire                     s_axi_arready,                // Read address ready
  // Read data channel
  output reg  [`SRCMB_DATA_W-1:0] s_axi_rdata,                  // Read data
  output reg  [1:0]               s_axi_rresp,                  // Read response
  output reg                      s_axi_rvalid,                 // Read data valid
  input  wire                     s_axi_rready,                 // Read data ready
  // Reset sources
  input  wire                     power_on_reset,               // Power-on detector, high = active
  input  wire                     external_clear_pin_n,         // Master-clear pin, low = active
  input  wire                     watchdog_reset_source,        // Watchdog timeout, high = active
  input  wire                     brownout_reset_source,        // Brown-out detector, high = active
  input  wire                     config_mismatch_reset_source, // Configuration mismatch, high = active
  input  wire                     system_unlocked,              // Unlock sequence in effect, level
  // Reset outputs
  output reg                      software_reset_source,        // One-cycle software reset event
  output wire                     master_system_reset           // Chip-wide reset, high = active
);

  // Write side states
  localparam [1:0] WS_COLLECT = 2'b01;
  localparam [1:0] WS_RESP    = 2'b10;

  // Read side states
  localparam [1:0] RS_IDLE    = 2'b01;
  localparam [1:0] RS_DATA    = 2'b10;

  // Register select codes, one-hot
  localparam [1:0] SEL_NONE    = 2'b00;
  localparam [1:0] SEL_TRIGGER = 2'b01;
  localparam [1:0] SEL_STATUS  = 2'b10;

  reg  [1:0]               wr_state;
  reg  [1:0]               rd_state;
  reg                      aw_got;
  reg                      w_got;
  reg  [`SRCMB_ADDR_W-1:0] aw_addr_q;
  reg  [`SRCMB_DATA_W-1:0] w_data_q;
  reg  [3:0]               w_strb_q;
  reg                      soft_reset_trigger_bit;
  reg                      write_rejected;

  wire                     aw_hs;
  wire                     w_hs;
  wire                     ar_hs;
  wire                     have_aw;
  wire                     have_w;
  wire                     do_write;
  wire [`SRCMB_ADDR_W-1:0] wr_addr;
  wire [`SRCMB_DATA_W-1:0] wr_data;
  wire [3:0]               wr_strb;
  wire [1:0]               wr_sel;
  wire [1:0]               rd_sel;
  wire                     trig_one;
  wire                     trig_accept;
  wire                     trig_refuse;
  wire                     rej_clear;
  wire [`SRCMB_NUM_SRC-1:0] src_active;
  wire [`SRCMB_DATA_W-1:0] status_word;

  // Address decode shared by both channels; low word bits must be zero
  function [1:0] srcmb_decode;
    input [`SRCMB_ADDR_W-1:0] addr;
    begin
      case (addr)
        `SRCMB_OFS_TRIGGER: srcmb_decode = SEL_TRIGGER;
        `SRCMB_OFS_STATUS:  srcmb_decode = SEL_STATUS;
        default:            srcmb_decode = SEL_NONE;
      endcase
    end
  endfunction

  // Handshakes; each channel is taken at most once per write
  assign s_axi_awready = (wr_state == WS_COLLECT) && !aw_got;
  assign s_axi_wready  = (wr_state == WS_COLLECT) && !w_got;
  assign s_axi_arready = (rd_state == RS_IDLE);
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;

  // The write fires on the edge that completes the address and data pair
  assign have_aw  = aw_got || aw_hs;
  assign have_w   = w_got || w_hs;
  assign do_write = (wr_state == WS_COLLECT) && have_aw && have_w;
  assign wr_addr  = aw_got ? aw_addr_q : s_axi_awaddr;
  assign wr_data  = w_got ? w_data_q : s_axi_wdata;
  assign wr_strb  = w_got ? w_strb_q : s_axi_wstrb;
  assign wr_sel   = srcmb_decode(wr_addr);
  assign rd_sel   = srcmb_decode(s_axi_araddr);

  // Only bit 0 of the trigger word counts; upper bits are dropped
  assign trig_one    = do_write && (wr_sel == SEL_TRIGGER) && wr_strb[0] &&
                       wr_data[`SRCMB_TRIG_BIT];
  // A locked write of one is refused and only leaves a sticky mark
  assign trig_accept = trig_one && system_unlocked;
  assign trig_refuse = trig_one && !system_unlocked;
  assign rej_clear   = do_write && (wr_sel == SEL_STATUS) && wr_strb[1] &&
                       wr_data[`SRCMB_ST_REJECTED];

  // Write side: collect address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_state     <= WS_COLLECT;
      aw_got       <= 1'b0;
      w_got        <= 1'b0;
      aw_addr_q    <= {`SRCMB_ADDR_W{1'b0}};
      w_data_q     <= `SRCMB_RST_WORD;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SRCMB_RESP_OKAY;
    end else begin
      case (wr_state)
        WS_COLLECT: begin
          if (aw_hs) begin
            aw_got    <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
          end
          if (w_hs) begin
            w_got    <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
          end
          if (do_write) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // A locked trigger write still completes with OKAY
            s_axi_bresp  <= (wr_sel == SEL_NONE) ? `SRCMB_RESP_SLVERR : `SRCMB_RESP_OKAY;
            wr_state     <= WS_RESP;
          end
        end
        WS_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SRCMB_RESP_OKAY;
            wr_state     <= WS_COLLECT;
          end
        end
        default: begin
          wr_state     <= WS_COLLECT;
          aw_got       <= 1'b0;
          w_got        <= 1'b0;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Trigger bit: set by an accepted write, cleared by hardware next edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      soft_reset_trigger_bit <= 1'b0;
    end else if (trig_accept) begin
      soft_reset_trigger_bit <= 1'b1;
    end else begin
      soft_reset_trigger_bit <= 1'b0;
    end
  end

  // Software reset event follows the trigger bit as a single pulse
  always @(posedge aclk) begin
    if (!aresetn) begin
      software_reset_source <= 1'b0;
    end else begin
      software_reset_source <= soft_reset_trigger_bit;
    end
  end

  // Refused-write mark; a new refusal wins over a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      write_rejected <= 1'b0;
    end else if (trig_refuse) begin
      write_rejected <= 1'b1;
    end else if (rej_clear) begin
      write_rejected <= 1'b0;
    end
  end

  // Six causes, all turned active high before merging
  assign src_active = {config_mismatch_reset_source,
                       brownout_reset_source,
                       watchdog_reset_source,
                       software_reset_source,
                       !external_clear_pin_n,
                       power_on_reset};

  // Merge and hold; the registered event joins, so timing stays clean
  srcmb_stretch #(
    .NUM_SRC (`SRCMB_NUM_SRC),
    .HOLD    (HOLD),
    .CNT_W   (CNT_W)
  ) u_stretch (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .src_active (src_active),
    .rst_out    (master_system_reset)
  );

  // Status word: live state of the block
  assign status_word = {{(`SRCMB_DATA_W-`SRCMB_ST_REJECTED-1){1'b0}},
                        write_rejected,
                        src_active,
                        master_system_reset,
                        system_unlocked};

  // Read side: address taken when idle, data one edge later
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_state     <= RS_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `SRCMB_RST_WORD;
      s_axi_rresp  <= `SRCMB_RESP_OKAY;
    end else begin
      case (rd_state)
        RS_IDLE: begin
          if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            rd_state     <= RS_DATA;
            case (rd_sel)
              SEL_TRIGGER: begin
                // Write-only: the whole word reads as zero
                s_axi_rdata <= `SRCMB_RST_WORD;
                s_axi_rresp <= `SRCMB_RESP_OKAY;
              end
              SEL_STATUS: begin
                s_axi_rdata <= status_word;
                s_axi_rresp <= `SRCMB_RESP_OKAY;
              end
              default: begin
                s_axi_rdata <= `SRCMB_RST_WORD;
                s_axi_rresp <= `SRCMB_RESP_SLVERR;
              end
            endcase
          end
        end
        RS_DATA: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `SRCMB_RST_WORD;
            s_axi_rresp  <= `SRCMB_RESP_OKAY;
            rd_state     <= RS_IDLE;
          end
        end
        default: begin
          rd_state     <= RS_IDLE;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: srcmb_map.vh
// Register map, field positions and timing constants of the system reset combiner
`ifndef SRCMB_MAP_VH
`define SRCMB_MAP_VH

// Bus geometry
`define SRCMB_ADDR_W          4
`define SRCMB_DATA_W          32

// Register byte offsets
`define SRCMB_OFS_TRIGGER     4'h0
`define SRCMB_OFS_STATUS      4'h4

// Trigger register fields
`define SRCMB_TRIG_BIT        0

// Status register fields
`define SRCMB_ST_UNLOCKED     0
`define SRCMB_ST_MASTER       1
`define SRCMB_ST_SRC_LO       2
`define SRCMB_ST_SRC_HI       7
`define SRCMB_ST_REJECTED     8

// Reset values
`define SRCMB_RST_WORD        32'h0000_0000

// AXI response codes
`define SRCMB_RESP_OKAY       2'h0
`define SRCMB_RESP_SLVERR     2'h2

// Source count and hold time after the last source releases
`define SRCMB_NUM_SRC         6
`define SRCMB_CLK_PERIOD_NS   10
`define SRCMB_HOLD_NS         160
`define SRCMB_HOLD_CYCLES     ((`SRCMB_HOLD_NS + `SRCMB_CLK_PERIOD_NS - 1) / `SRCMB_CLK_PERIOD_NS)

`endif

// file: srcmb_stretch.v
// Merges reset source levels and holds the master reset after release
`include "srcmb_map.vh"

module srcmb_stretch #(
  parameter NUM_SRC = `SRCMB_NUM_SRC,
  parameter HOLD    = `SRCMB_HOLD_CYCLES,
  parameter CNT_W   = 8
) (
  input  wire               aclk,        // System clock
  input  wire               aresetn,     // Synchronous reset, active low
  input  wire [NUM_SRC-1:0] src_active,  // One level per source, high = active
  output reg                rst_out      // Merged and stretched reset
);

  localparam [CNT_W-1:0] HOLD_CNT = HOLD[CNT_W-1:0];

  reg  [CNT_W-1:0] hold_cnt;
  wire             any_src;

  // Any one source is enough
  assign any_src = |src_active;

  // Reset stays asserted through the block's own reset, so the chip never
  // sees a released reset before the sources have been looked at
  always @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt <= HOLD_CNT;
      rst_out  <= 1'b1;
    end else if (any_src) begin
      hold_cnt <= HOLD_CNT;
      rst_out  <= 1'b1;
    end else if (hold_cnt != {CNT_W{1'b0}}) begin
      hold_cnt <= hold_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
      rst_out  <= 1'b1;
    end else begin
      hold_cnt <= hold_cnt;
      rst_out  <= 1'b0;
    end
  end

endmodule

// file: srcmb_assertions.sv
// Port-level checks of the system reset combiner
`include "srcmb_map.vh"
module srcmb_assertions #(
  parameter HOLD  = `SRCMB_HOLD_CYCLES,
  parameter CNT_W = 8
) (
  input wire        aclk,                         // Clock
  input wire        aresetn,                      // Reset, low
  input wire [3:0]  s_axi_awaddr,                 // AW addr
  input wire [2:0]  s_axi_awprot,                 // AW prot
  input wire        s_axi_awvalid,                // AW valid
  input wire        s_axi_awready,                // AW ready
  input wire [31:0] s_axi_wdata,                  // W data
  input wire [3:0]  s_axi_wstrb,                  // W strobes
  input wire        s_axi_wvalid,                 // W valid
  input wire        s_axi_wready,                 // W ready
  input wire [1:0]  s_axi_bresp,                  // B resp
  input wire        s_axi_bvalid,                 // B valid
  input wire        s_axi_bready,                 // B ready
  input wire [3:0]  s_axi_araddr,                 // AR addr
  input wire [2:0]  s_axi_arprot,                 // AR prot
  input wire        s_axi_arvalid,                // AR valid
  input wire        s_axi_arready,                // AR ready
  input wire [31:0] s_axi_rdata,                  // R data
  input wire [1:0]  s_axi_rresp,                  // R resp
  input wire        s_axi_rvalid,                 // R valid
  input wire        s_axi_rready,                 // R ready
  input wire        power_on_reset,               // Power-on
  input wire        external_clear_pin_n,         // Clear pin, low
  input wire        watchdog_reset_source,        // Watchdog
  input wire        brownout_reset_source,        // Brown-out
  input wire        config_mismatch_reset_source, // Mismatch
  input wire        system_unlocked,              // Unlock level
  input wire        software_reset_source,        // Soft pulse
  input wire        master_system_reset           // Master reset
);
  logic any_src;
  logic trig_wr;
  logic rd_trig;
  int   quiet;
  // Causes and same-edge trigger writes
  assign any_src = power_on_reset | ~external_clear_pin_n | watchdog_reset_source | brownout_reset_source
                   | config_mismatch_reset_source | software_reset_source;
  assign trig_wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0]
                   & (s_axi_awaddr == `SRCMB_OFS_TRIGGER);
  // Read target and quiet cycles since the last cause; saturate to avoid wrap
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_trig <= 1'b0;
      quiet   <= 0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rd_trig <= (s_axi_araddr == `SRCMB_OFS_TRIGGER);
      quiet <= any_src ? 0 : ((quiet < 1000) ? quiet + 1 : quiet);
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  src_to_master_a: assert property (any_src |=> master_system_reset)
    else $error("master reset missed an active cause");
  pulse_single_a: assert property (software_reset_source |=> !software_reset_source)
    else $error("software reset stayed set");
  trig_fire_a: assert property (trig_wr && s_axi_wdata[0] && system_unlocked |-> ##2 software_reset_source)
    else $error("accepted trigger gave no reset event");
  trig_blocked_a: assert property (trig_wr && !(s_axi_wdata[0] && system_unlocked) |-> ##2 !software_reset_source)
    else $error("ignored trigger gave a reset event");
  trig_reads_zero_a: assert property (s_axi_rvalid && rd_trig |-> s_axi_rdata == 32'h0000_0000)
    else $error("trigger register read not zero");
  master_hold_a: assert property ($fell(master_system_reset) |-> quiet >= HOLD - 1)
    else $error("master reset released too early");
endmodule
bind srcmb_top srcmb_assertions #(.HOLD(HOLD), .CNT_W(CNT_W)) chk (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_on_reset, .external_clear_pin_n,
  .watchdog_reset_source, .brownout_reset_source, .config_mismatch_reset_source, .system_unlocked,
  .software_reset_source, .master_system_reset);

// file: srcmb_top_bench.sv
// Self-checking bench of the system reset combiner
`include "srcmb_map.vh"
module srcmb_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD_T = 2;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, system_unlocked, software_reset_source;
  logic power_on_reset, external_clear_pin_n, watchdog_reset_source, brownout_reset_source;
  logic config_mismatch_reset_source, master_system_reset;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, src;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int mismatches, num_checks, pulse_cnt, mst_cnt;
  srcmb_top #(.HOLD(HOLD_T)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .power_on_reset, .external_clear_pin_n, .watchdog_reset_source,
    .brownout_reset_source, .config_mismatch_reset_source, .system_unlocked, .software_reset_source,
    .master_system_reset);
  // Clock and run limit
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    time_out();
  end
  // Cycles of pulse and master reset, kept apart from the design's own logic
  always @(posedge aclk) begin
    if (software_reset_source === 1'b1) pulse_cnt <= pulse_cnt + 1;
    if (master_system_reset === 1'b1) mst_cnt <= mst_cnt + 1;
  end
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic time_out();
    check_val("wait bound", 0, 1);
    print_verdict();
  endtask
  // Channels are judged at the negedge, where the next edge's values are already settled
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hit, w_hit, b_hit;
    int n;
    b_hit = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; !b_hit; n++) begin
      if (n == 30) time_out();
      @(negedge aclk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      if (b_hit) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hit, r_hit;
    int n;
    r_hit = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; !r_hit; n++) begin
      if (n == 30) time_out();
      @(negedge aclk);
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_hit = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
      if (r_hit) s_axi_rready <= 1'b0;
    end
  endtask
  task automatic wait_low(output int cyc);
    for (cyc = 0; cyc < 60; cyc++) begin
      @(negedge aclk);
      if (master_system_reset === 1'b0) return;
    end
    time_out();
  endtask
  // One trigger write, then count event and master cycles
  task automatic trig_write(input logic [3:0] a, input logic [31:0] d, input logic u, input int exp);
    logic [1:0] r;
    int p0, m0, cyc;
    @(posedge aclk);
    p0 = pulse_cnt;
    m0 = mst_cnt;
    system_unlocked <= u;
    axi_write(a, d, r);
    check_val("bresp", (a == `SRCMB_OFS_TRIGGER) ? `SRCMB_RESP_OKAY : `SRCMB_RESP_SLVERR, r);
    repeat (8) @(posedge aclk);
    check_val("pulse cycles", exp, pulse_cnt - p0);
    check_val("master set", exp, mst_cnt != m0);
    wait_low(cyc);
  endtask
  task automatic test_sources();
    int i, cyc;
    for (i = 0; i < 5; i++) begin
      @(posedge aclk);
      power_on_reset <= (i == 0);
      external_clear_pin_n <= (i != 1);
      src <= (i < 2) ? 4'h0 : ((i == 4) ? 4'h1 : (4'h1 << i));
      @(posedge aclk);
      power_on_reset <= 1'b0;
      external_clear_pin_n <= 1'b1;
      src <= 4'h0;
      @(negedge aclk);
      check_val("master on cause", 1, master_system_reset);
      wait_low(cyc);
      check_val("master held", 1, cyc >= HOLD_T);
    end
  endtask
  task automatic test_reads();
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    axi_read(`SRCMB_OFS_TRIGGER, d, r);
    check_val("trigger read", 32'h0000_0000, d);
    check_val("trigger rresp", `SRCMB_RESP_OKAY, r);
    axi_read(4'h8, d, r);
    check_val("unmapped rresp", `SRCMB_RESP_SLVERR, r);
    // Earlier locked write left the refused mark; unlock still high
    axi_read(`SRCMB_OFS_STATUS, d, r);
    check_val("status word", 32'h0000_0101, d);
  endtask
  assign watchdog_reset_source = src[2];
  assign brownout_reset_source = src[3];
  assign config_mismatch_reset_source = src[0];
  // Main sequence
  initial begin
    int cyc;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, src} = '0;
    {power_on_reset, system_unlocked, pulse_cnt, mst_cnt, mismatches, num_checks} = '0;
    s_axi_wstrb = 4'hF;
    external_clear_pin_n = 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    wait_low(cyc);
    check_val("release hold", 1, cyc >= HOLD_T);
    test_sources();
    trig_write(`SRCMB_OFS_TRIGGER, 32'h0000_0001, 1'b1, 1);
    trig_write(`SRCMB_OFS_TRIGGER, 32'h0000_0001, 1'b0, 0);
    trig_write(`SRCMB_OFS_TRIGGER, 32'h0000_0000, 1'b1, 0);
    trig_write(`SRCMB_OFS_TRIGGER, 32'hFFFF_FFFE, 1'b1, 0);
    trig_write(4'h8, 32'h0000_0001, 1'b1, 0);
    test_reads();
    print_verdict();
  end
endmodule
